/* tb_top.sv */
// Purpose: Self-checking bench for the watchdog register block
// Assumes: Seconds prescaler shortened to SEC cycles
// Notes: All waits bounded; a spent bound counts as a mismatch
`timescale 1ns/100ps
module tb_top;
   localparam int SEC = 10; // Short second so minutes fit the run
   logic clk_i, rst_i, sby_rst_i, cyc_i, stb_i, we_i, ack_o, int_o;
   logic [11:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [15:0] isa_irq_o;
   logic gp, kb, ms, kf;
   logic [3:0] maps [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
   int err_total, samples_checked, n;
   wdt_aux_io #(.SEC_CYCLES(SEC), .ADR_W(12)) DUT (.clk_i(clk_i), .rst_i(rst_i), .sby_rst_i(sby_rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .game_port_access_i(gp), .kbd_irq_i(kb), .mouse_irq_i(ms), .kbc_force_line_i(kf),
      .isa_irq_o(isa_irq_o), .int_o(int_o));
   wdt_host_model host (.clk_i(clk_i), .game_port_access_o(gp), .kbd_irq_o(kb), .mouse_irq_o(ms),
      .kbc_force_line_o(kf));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Classic single cycle; data taken and request released at the edge where ack is seen high
   task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {2'h0, idx, 2'h0};
      dat_i <= {24'h0, d};
      sel_i <= 4'hF;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack_o !== 1'b1 && k < 20);
      if (ack_o !== 1'b1)
      begin
         err_total++;
         end_of_test();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      wb(idx, 1'b0, 8'h00);
      check(rd, {24'h0, exp});
   endtask
   // Cycles until the routed line rises, bounded
   task automatic wait_irq(input int lo, input int hi);
      n = 0;
      while (isa_irq_o[3] !== 1'b1 && n <= hi)
      begin
         @(negedge clk_i);
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   // Status 0 clears the timeout; irq status cleared too
   task automatic clr();
      wb(wdt_pkg::IDX_CTRL, 1'b1, 8'h00);
      wb(wdt_pkg::IDX_IRQ_CLEAR, 1'b1, 8'h03);
   endtask
   initial
   begin
      {rst_i, sby_rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {2'h3, 51'h0};
      err_total = 0;
      samples_checked = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      sby_rst_i <= 1'b0;
      // Reset values, F8 unmapped
      for (int i = 0; i < 8; i++) rdchk(8'hF1 + i[7:0], 8'h00);
      wb(wdt_pkg::IDX_SOURCE, 1'b1, 8'h30);
      wb(wdt_pkg::IDX_IRQ_ENABLE, 1'b1, 8'h03);
      wb(wdt_pkg::IDX_UNITS, 1'b1, 8'h80);
      wb(wdt_pkg::IDX_VALUE, 1'b1, 8'h02);
      wait_irq(2 * SEC - 1, 2 * SEC + 6);
      @(negedge clk_i);
      check({31'h0, int_o}, 32'h1);
      rdchk(wdt_pkg::IDX_CTRL, 8'h01);
      rdchk(wdt_pkg::IDX_IRQ_STATUS, 8'h01);
      // Five mapping codes (0, 1, 2, 3, F) while status is set
      foreach (maps[i])
      begin
         wb(wdt_pkg::IDX_SOURCE, 1'b1, {maps[i], 4'h0});
         repeat (2) @(negedge clk_i);
         check({16'h0, isa_irq_o}, (maps[i] == 4'h0 || maps[i] == 4'h2) ? 32'h0 : 32'h1 << maps[i]);
      end
      wb(wdt_pkg::IDX_SOURCE, 1'b1, 8'h30);
      wb(wdt_pkg::IDX_IRQ_ENABLE, 1'b1, 8'h00);
      repeat (2) @(negedge clk_i);
      check({31'h0, int_o}, 32'h0);
      wb(wdt_pkg::IDX_IRQ_ENABLE, 1'b1, 8'h01);
      repeat (2) @(negedge clk_i);
      check({31'h0, int_o}, 32'h1);
      wb(wdt_pkg::IDX_VALUE, 1'b1, 8'h00);
      clr();
      repeat (60) @(negedge clk_i);
      check({16'h0, isa_irq_o, 15'h0, int_o}, 32'h0);
      // Enabled sources keep restarting the count
      wb(wdt_pkg::IDX_SOURCE, 1'b1, 8'h37);
      wb(wdt_pkg::IDX_VALUE, 1'b1, 8'h02);
      for (int i = 0; i < 6; i++)
      begin
         repeat (12) @(negedge clk_i);
         host.pulse(i % 3);
      end
      check({16'h0, isa_irq_o}, 32'h0);
      // Disabled sources must not restart
      wb(wdt_pkg::IDX_SOURCE, 1'b1, 8'h30);
      wb(wdt_pkg::IDX_VALUE, 1'b1, 8'h02);
      repeat (6) @(negedge clk_i);
      for (int s = 2; s >= 0; s--) host.pulse(s);
      wait_irq(1, 9);
      wb(wdt_pkg::IDX_VALUE, 1'b1, 8'h00);
      clr();
      wb(wdt_pkg::IDX_CTRL, 1'b1, 8'h04);
      wait_irq(1, 5);
      rdchk(wdt_pkg::IDX_CTRL, 8'h01);
      clr();
      // Force line ignored while disabled, then an edge forces once
      host.pulse(3);
      rdchk(wdt_pkg::IDX_IRQ_STATUS, 8'h00);
      wb(wdt_pkg::IDX_CTRL, 1'b1, 8'h08);
      fork
         host.pulse(3);
      join_none
      wait_irq(1, 10);
      wb(wdt_pkg::IDX_IRQ_STATUS, 1'b0, 8'h00);
      check(rd & 32'h2, 32'h2);
      wb(wdt_pkg::IDX_CTRL, 1'b1, 8'h08);
      wb(wdt_pkg::IDX_IRQ_CLEAR, 1'b1, 8'h03);
      repeat (20) @(negedge clk_i);
      check({16'h0, isa_irq_o}, 32'h0);
      repeat (130) @(negedge clk_i);
      // Status bit written by the host, then cleared again
      wb(wdt_pkg::IDX_CTRL, 1'b1, 8'h01);
      rdchk(wdt_pkg::IDX_CTRL, 8'h01);
      wb(wdt_pkg::IDX_CTRL, 1'b1, 8'h00);
      rdchk(wdt_pkg::IDX_CTRL, 8'h00);
      // Minutes timebase
      wb(wdt_pkg::IDX_UNITS, 1'b1, 8'h00);
      wb(wdt_pkg::IDX_VALUE, 1'b1, 8'h01);
      wait_irq(60 * SEC - 1, 60 * SEC + 6);
      end_of_test();
   end
endmodule
bind wdt_aux_io wdt_aux_chk #(.ADR_W(ADR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .isa_irq_o(isa_irq_o),
   .int_o(int_o));

/* wdt_aux_chk.sv */
// Purpose: Port-level assertions for the watchdog register block
// Assumes: One clock, rst_i synchronous active high
// Notes: Attached by bind from the testbench top
`timescale 1ns/100ps
module wdt_aux_chk
#(
   parameter int ADR_W = 12
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Interrupts
   input wire logic [15:0] isa_irq_o,
   input wire logic int_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Register index of the held request and read answer cycle
   wire logic [ADR_W-3:0] idx = adr_i[ADR_W-1:2];
   wire logic rd_ack = ack_o && !we_i;
   wire logic mapped = (idx >= 'hF1) && (idx <= 'hF7);
   wire logic wr_ack = ack_o && we_i;

   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held past one cycle");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
   ctrl_read_a:
      assert property (rd_ack && idx == wdt_pkg::IDX_CTRL |-> dat_o[7:4] == 4'h0 && dat_o[2:1] == 2'h0)
      else $error("control read shows write-only or reserved bits");
   units_read_a:
      assert property (rd_ack && idx == wdt_pkg::IDX_UNITS |-> dat_o[6:0] == 7'h0) else $error("units reserved bits set");
   unmapped_read_a: assert property (rd_ack && !mapped |-> dat_o == 32'h0) else $error("unmapped read not zero");
   irq_line_a:
      assert property ($onehot0(isa_irq_o) && !isa_irq_o[0] && !isa_irq_o[2]) else $error("illegal interrupt line");
   irq_hold_a:
      assert property ($fell(|isa_irq_o) |-> $past(wr_ack, 1) || $past(wr_ack, 2) || $past(wr_ack, 3))
      else $error("interrupt line dropped without a write");
   reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && isa_irq_o == 16'h0 && !int_o)
      else $error("outputs not cleared by reset");
   // Main scenarios
   cover property (rd_ack && idx == wdt_pkg::IDX_CTRL && dat_o[0]);
   cover property ($rose(int_o));
   cover property ($rose(isa_irq_o[15]));
endmodule

/* wdt_aux_io.sv */
// Purpose: Auxiliary watchdog timer with restart sources and ISA interrupt routing
// Assumes: Classic Wishbone slave, 32-bit data, registers at four times their index
// Notes: Configuration resets on rst_i, control on sby_rst_i
// Function
// - Units bit 7 picks minutes or seconds
// - Timeout value zero disables the watchdog
// - Nonzero value counts that many binary units
// - Source bit 0: game port access restarts
// - Source bit 1: keyboard interrupt restarts
// - Source bit 2: mouse interrupt restarts
// - Upper source nibble selects ISA interrupt line
// - Control bit 0 reads timeout status
// - Control bit 2 forces timeout, self clears
// - Control bit 3 enables force line timeouts
// - Force line rising edge pulses, ORed in
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
module wdt_aux_io
#(
   parameter int SEC_CYCLES = wdt_pkg::SEC_CYCLES,
   parameter int ADR_W = 12
)
(
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sby_rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Restart sources
   input wire logic game_port_access_i,
   input wire logic kbd_irq_i,
   input wire logic mouse_irq_i,
   // Keyboard controller force line
   input wire logic kbc_force_line_i,
   // Interrupts
   output logic [15:0] isa_irq_o,
   output logic int_o
);

   // The host sees four watchdog registers and three interrupt registers;
   // each sits in the low byte of its word and the upper bytes read as zero,
   // so byte lanes other than lane 0 are simply ignored on writes.

   // Address decode helper, one word per register index
   function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
      reg_hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
   endfunction

   // Map nibble to one-hot ISA line; disable and the invalid code drive nothing
   function automatic logic [15:0] irq_map(input logic [3:0] code);
      logic [15:0] onehot;
      // Shift first, then veto the two codes that must not drive a line
      onehot = 16'h0001 << code;
      if (code == wdt_pkg::MAP_DISABLE || code == wdt_pkg::MAP_INVALID)
         irq_map = 16'h0000;
      else
         irq_map = onehot;
   endfunction

   // Configuration clears on the bus reset, state and control only on the
   // standby reset, so a bus reset does not hide a timeout that already
   // happened; software must read the status after a bus reset.
   // Registers
   logic unit_sec; // Timebase select, seconds when set
   logic [7:0] count_value; // Programmed timeout in units
   logic [7:0] source_cfg; // Restart enables and interrupt map
   logic kbc_force_en; // Force line may trigger a timeout
   logic force_q; // Software force pulse, self clearing
   logic kbc_pulse_q; // Force line edge pulse, self clearing
   logic [1:0] irq_status; // Sticky event bits
   logic [1:0] irq_enable; // Event mask
   logic [7:0] remain; // Units left before expiry
   wdt_pkg::wdt_state_t state; // Watchdog state
   wdt_pkg::wdt_state_t next_state;

   // Pin synchronisers: bit 0 force line, bit 1 keyboard, bit 2 mouse
   logic [2:0] pin_meta; // First stage, read only by second stage
   logic [2:0] pin_sync; // Second stage
   logic [2:0] pin_prev; // Delayed copy for edge detection
   wire [2:0] pin_raw = {mouse_irq_i, kbd_irq_i, kbc_force_line_i};
   wire [2:0] pin_rise = pin_sync & ~pin_prev;

   // These lines come from logic with its own timing, so each passes two
   // flops and the edge detector reads only the second one. All stages reset
   // to the idle low level, so no false edge follows a reset.
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         // Two flops before any logic looks at the pin
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               pin_meta[g] <= 1'b0;
               pin_sync[g] <= 1'b0;
               pin_prev[g] <= 1'b0;
            end
            else
            begin
               pin_meta[g] <= pin_raw[g];
               pin_sync[g] <= pin_meta[g];
               pin_prev[g] <= pin_sync[g];
            end
         end
      end
   endgenerate

   // Bus request qualifiers; a write lands on the edge where ack is high
   // Qualifying with ack_o makes each request write exactly once, on the
   // same edge where the master samples the acknowledge.
   wire bus_req = cyc_i && stb_i;
   wire bus_wr = bus_req && we_i && ack_o && sel_i[0];
   wire [7:0] wr_byte = dat_i[7:0];

   // Per-register write strobes
   wire wr_units = bus_wr && reg_hit(adr_i, wdt_pkg::IDX_UNITS);
   wire wr_value = bus_wr && reg_hit(adr_i, wdt_pkg::IDX_VALUE);
   wire wr_source = bus_wr && reg_hit(adr_i, wdt_pkg::IDX_SOURCE);
   wire wr_ctrl = bus_wr && reg_hit(adr_i, wdt_pkg::IDX_CTRL);
   wire wr_irq_clr = bus_wr && reg_hit(adr_i, wdt_pkg::IDX_IRQ_CLEAR);
   wire wr_irq_en = bus_wr && reg_hit(adr_i, wdt_pkg::IDX_IRQ_ENABLE);

   // Status bit writes from the control register
   wire status_wr0 = wr_ctrl && !wr_byte[wdt_pkg::CTRL_STATUS_BIT];
   wire status_wr1 = wr_ctrl && wr_byte[wdt_pkg::CTRL_STATUS_BIT];
   wire force_wr = wr_ctrl && wr_byte[wdt_pkg::CTRL_FORCE_BIT];

   // Restart sources, each gated by its enable
   // The game port strobe is already on this clock and is used as is; the
   // interrupt inputs restart on their rising edge only, so a level stuck
   // high cannot keep the watchdog from ever expiring.
   wire rst_game = game_port_access_i && source_cfg[wdt_pkg::SRC_GAME_BIT];
   wire rst_kbd = pin_rise[1] && source_cfg[wdt_pkg::SRC_KBD_BIT];
   wire rst_mouse = pin_rise[2] && source_cfg[wdt_pkg::SRC_MOUSE_BIT];
   wire restart = rst_game || rst_kbd || rst_mouse || wr_value;

   // Timeout causes; a forced one works whatever the value register holds
   // Expiry is taken on the tick that ends the last unit, so a value of N
   // gives N full units after counting starts.
   wire value_zero = (count_value == 8'h00);
   wire unit_tick;
   wire expire = (state == wdt_pkg::WDT_ST_RUN) && unit_tick && (remain == 8'h01);
   wire forced = force_q || kbc_pulse_q;
   wire timeout_evt = expire || forced;
   wire status = (state == wdt_pkg::WDT_ST_EXP);

   // Timebase held in restart unless running, so each run starts on a unit boundary
   // Restarting it on a host write means a value written just before a unit
   // boundary still gets its full first unit.
   wdt_tick #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(restart || (state != wdt_pkg::WDT_ST_RUN)),
      .unit_sec_i(unit_sec),
      .tick_o(unit_tick)
   );

   // OFF: value zero or just cleared; RUN: counting; EXP: status reads one.
   // A status write of one is taken as a request to show a timeout.
   // Next state; a timeout wins over any host write in the same cycle
   always_comb
   begin
      next_state = state;
      case (state)
         wdt_pkg::WDT_ST_OFF:
         begin
            if (timeout_evt || status_wr1)
               next_state = wdt_pkg::WDT_ST_EXP;
            else if (!value_zero)
               next_state = wdt_pkg::WDT_ST_RUN;
         end
         wdt_pkg::WDT_ST_RUN:
         begin
            if (timeout_evt || status_wr1)
               next_state = wdt_pkg::WDT_ST_EXP;
            else if (value_zero)
               next_state = wdt_pkg::WDT_ST_OFF;
         end
         wdt_pkg::WDT_ST_EXP:
         begin
            // Clearing the status bit resumes counting from the full value
            if (status_wr0 && !timeout_evt)
               next_state = wdt_pkg::WDT_ST_OFF;
         end
         default:
            next_state = wdt_pkg::WDT_ST_OFF;
      endcase
   end

   // State lives with the control register on the standby reset
   always_ff @(posedge clk_i)
   begin
      if (sby_rst_i)
         state <= wdt_pkg::WDT_ST_OFF;
      else
         state <= next_state;
   end

   // Remaining units; reloaded on any restart or while not running
   // A value write loads the new count directly, since count_value takes it
   // on the same edge and the reload path would still see the old one.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         remain <= wdt_pkg::RST_VALUE;
      else if (wr_value)
         remain <= wr_byte;
      else if (restart || state != wdt_pkg::WDT_ST_RUN)
         remain <= count_value;
      else if (unit_tick)
         remain <= remain - 8'h01;
   end

   // Configuration registers, cleared by the bus reset
   // Reserved source bit 3 is stored but always reads as zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         unit_sec <= wdt_pkg::RST_UNITS[wdt_pkg::UNITS_SEC_BIT];
         count_value <= wdt_pkg::RST_VALUE;
         source_cfg <= wdt_pkg::RST_SOURCE;
      end
      else
      begin
         if (wr_units)
            unit_sec <= wr_byte[wdt_pkg::UNITS_SEC_BIT];
         if (wr_value)
            count_value <= wr_byte;
         if (wr_source)
            source_cfg <= wr_byte;
      end
   end

   // Control register: force enable and the two self-clearing pulses
   // Both pulses are one cycle wide; a force while already expired only
   // sets the event bit again.
   always_ff @(posedge clk_i)
   begin
      if (sby_rst_i)
      begin
         kbc_force_en <= wdt_pkg::RST_CTRL[wdt_pkg::CTRL_KBC_EN_BIT];
         force_q <= 1'b0;
         kbc_pulse_q <= 1'b0;
      end
      else
      begin
         // Upper bits are not stored; host is expected to write them as zero
         if (wr_ctrl)
            kbc_force_en <= wr_byte[wdt_pkg::CTRL_KBC_EN_BIT];
         // Force bit lasts one cycle whatever was written before
         force_q <= force_wr;
         // A line held high gives one pulse only, on its rising edge
         kbc_pulse_q <= pin_rise[0] && kbc_force_en;
      end
   end

   // Sticky event bits; a new event wins over a clear in the same cycle
   // Bit 0 records any timeout, bit 1 only those caused by the force line
   wire [1:0] irq_event = {kbc_pulse_q, timeout_evt};
   wire [1:0] irq_clear = wr_irq_clr ? wr_byte[1:0] : 2'h0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status <= 2'h0;
         irq_enable <= wdt_pkg::RST_IRQ_ENABLE;
      end
      else
      begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
         if (wr_irq_en)
            irq_enable <= wr_byte[1:0];
      end
   end

   // Interrupt outputs are registered to keep glitches off the pins
   // The line follows the status, not the event bit, so it stays up until
   // software clears the status; the map may be changed while it is up.
   wire [15:0] next_isa_irq = status ? irq_map(source_cfg[7:4]) : 16'h0000;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         isa_irq_o <= 16'h0000;
         int_o <= 1'b0;
      end
      else
      begin
         isa_irq_o <= next_isa_irq;
         int_o <= |(irq_status & irq_enable);
      end
   end

   // Read data; reserved bits and write-only fields read as zero
   // Built from live values in the request cycle and registered into dat_o,
   // so the data stands exactly in the ack cycle.
   wire [7:0] rd_units = {unit_sec, 7'h00};
   wire [7:0] rd_source = {source_cfg[7:4], 1'b0, source_cfg[2:0]};
   wire [7:0] rd_ctrl = {4'h0, kbc_force_en, 2'h0, status};
   wire [7:0] rd_irq_st = {6'h00, irq_status};
   wire [7:0] rd_irq_en = {6'h00, irq_enable};

   wire [7:0] rd_byte =
      reg_hit(adr_i, wdt_pkg::IDX_UNITS) ? rd_units :
      reg_hit(adr_i, wdt_pkg::IDX_VALUE) ? count_value :
      reg_hit(adr_i, wdt_pkg::IDX_SOURCE) ? rd_source :
      reg_hit(adr_i, wdt_pkg::IDX_CTRL) ? rd_ctrl :
      reg_hit(adr_i, wdt_pkg::IDX_IRQ_STATUS) ? rd_irq_st :
      reg_hit(adr_i, wdt_pkg::IDX_IRQ_ENABLE) ? rd_irq_en :
      8'h00;

   // Single-wait-state slave: ack one cycle after the request, dropped after one
   // The !ack_o term keeps a held request from being answered twice
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end
      else
      begin
         ack_o <= bus_req && !ack_o;
         // Unmapped addresses answer normally with zero data
         dat_o <= (bus_req && !ack_o && !we_i) ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

endmodule

/* wdt_host_model.sv */
// Purpose: Model of the restart sources and keyboard controller force line
// Assumes: Lines idle low, driven just after a rising edge
// Notes: Force line is held high for its documented minimum
`timescale 1ns/100ps
module wdt_host_model
(
   // Clock
   input wire logic clk_i,
   // Source lines
   output logic game_port_access_o,
   output logic kbd_irq_o,
   output logic mouse_irq_o,
   output logic kbc_force_line_o
);
   logic [3:0] lines; // Bit per source: game, kbd, mouse, force line
   assign {kbc_force_line_o, mouse_irq_o, kbd_irq_o, game_port_access_o} = lines;
   initial lines = 4'h0;
   // One event on source s; async levels are held so the sync flops see them
   task automatic pulse(input int s);
      int n;
      n = (s == 0) ? 1 : (s == 3) ? wdt_pkg::KBC_HIGH_MIN_CYC : 4;
      @(posedge clk_i);
      lines <= 4'h1 << s;
      repeat (n) @(posedge clk_i);
      lines <= 4'h0;
   endtask
endmodule

/* wdt_pkg.sv */
// Purpose: Shared constants and types for the auxiliary watchdog block
// Assumes: 125 MHz core clock, 32-bit classic Wishbone register port
// Notes: Register indices are word indices; byte address is index times four
package wdt_pkg;
   // Clock and timebase
   localparam int CLK_PERIOD_NS = 8;
   localparam longint SEC_NS = 1000000000;
   localparam int SEC_CYCLES = int'(SEC_NS / CLK_PERIOD_NS);
   localparam logic [5:0] SEC_PER_MIN = 6'h3C;
   // Shortest high time of the keyboard controller force line
   localparam int KBC_HIGH_MIN_NS = 1000;
   localparam int KBC_HIGH_MIN_CYC = (KBC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register indices
   localparam logic [7:0] IDX_UNITS = 8'hF1;
   localparam logic [7:0] IDX_VALUE = 8'hF2;
   localparam logic [7:0] IDX_SOURCE = 8'hF3;
   localparam logic [7:0] IDX_CTRL = 8'hF4;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hF5;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'hF6;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hF7;

   // Reset values
   localparam logic [7:0] RST_UNITS = 8'h00;
   localparam logic [7:0] RST_VALUE = 8'h00;
   localparam logic [7:0] RST_SOURCE = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;

   // Field positions
   localparam int UNITS_SEC_BIT = 7;
   localparam int SRC_GAME_BIT = 0;
   localparam int SRC_KBD_BIT = 1;
   localparam int SRC_MOUSE_BIT = 2;
   localparam int SRC_MAP_LSB = 4;
   localparam int CTRL_STATUS_BIT = 0;
   localparam int CTRL_FORCE_BIT = 2;
   localparam int CTRL_KBC_EN_BIT = 3;
   localparam int IRQ_EXPIRE_BIT = 0;
   localparam int IRQ_KBC_BIT = 1;

   // Interrupt mapping codes
   localparam logic [3:0] MAP_DISABLE = 4'h0;
   localparam logic [3:0] MAP_INVALID = 4'h2;

   // Watchdog state, Gray coded along off, run, expired
   typedef enum logic [1:0]
   {
      WDT_ST_OFF = 2'h0,
      WDT_ST_RUN = 2'h1,
      WDT_ST_EXP = 2'h3
   } wdt_state_t;
endpackage

/* wdt_tick.sv */
// Purpose: Timebase for the watchdog, one pulse per second or per minute
// Assumes: Restart is a same-clock pulse or level
// Notes: The second prescaler is a parameter so simulation can shorten it
`timescale 1ns/100ps
module wdt_tick
#(
   parameter int SEC_CYCLES = wdt_pkg::SEC_CYCLES
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic restart_i,
   input wire logic unit_sec_i,
   // Unit elapsed pulse
   output logic tick_o
);
   localparam int CW = $clog2(SEC_CYCLES + 1);
   localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYCLES - 1);

   logic [CW-1:0] cyc_cnt; // Cycles within the current second
   logic [5:0] sec_cnt; // Seconds within the current minute
   wire sec_done = (cyc_cnt == SEC_LAST);
   wire min_done = sec_done && (sec_cnt == wdt_pkg::SEC_PER_MIN - 6'h01);

   // Restart clears both stages so a full unit always follows
   always_ff @(posedge clk_i)
   begin
      if (rst_i || restart_i)
      begin
         cyc_cnt <= '0;
         sec_cnt <= 6'h00;
         tick_o <= 1'b0;
      end
      else
      begin
         cyc_cnt <= sec_done ? '0 : cyc_cnt + CW'(1);
         if (sec_done)
            sec_cnt <= min_done ? 6'h00 : sec_cnt + 6'h01;
         tick_o <= unit_sec_i ? sec_done : min_done;
      end
   end
endmodule
